// ===== sarc_pkg.sv
/*
  sarc_pkg: constants, types and helpers shared by the converter control
  logic and its approximation engine.
  Assumes a single 125 MHz system clock; no other package is needed.
*/
package sarc_pkg;

  localparam int unsigned RES_W = 12;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // internal approximation clock period, one bit decision per tick
  localparam int unsigned SAR_BIT_NS = 80;
  localparam int unsigned SAR_BIT_CYC =
    (SAR_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SAR_BIT_LAST = 8'(SAR_BIT_CYC - 1);
  // ticks spent acquiring the input before the first decision
  localparam logic [1:0] ACQ_TICKS_LAST = 2'h1;
  localparam logic [3:0] IDX_MSB = 4'hB;
  localparam logic [3:0] IDX_END8 = 4'h4;
  localparam logic [3:0] IDX_END12 = 4'h0;
  localparam logic [3:0] PAD8 = 4'h8;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_CLR = 8'h0C;
  localparam logic [7:0] ADDR_INT_EN = 8'h10;
  localparam int unsigned CTRL_PIN_DIS_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_LEN8_BIT = 1;
  localparam int unsigned STAT_RES_LSB = 16;
  localparam int unsigned INT_DONE_BIT = 0;
  localparam int unsigned INT_IGN_BIT = 1;
  localparam logic [1:0] INT_RST = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // control pins as seen by the block
  typedef struct packed {
    logic chipEn;
    logic selN;
    logic readConv;
    logic wordWide;
    logic lenByteSel;
    logic compKeep;
  } sarc_pins_t;
  localparam sarc_pins_t PINS_RST = 6'h1A;

  // result lanes: drive value and enable per lane
  typedef struct packed {
    logic [RES_W-1:0] data;
    logic [RES_W-1:0] oe;
  } sarc_dbus_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACQ = 3'h2,
    ST_CONV = 3'h4
  } sarc_state_t;

  function automatic logic isLastBit(input logic [3:0] idx,
                                     input logic len8);
    return idx == (len8 ? IDX_END8 : IDX_END12);
  endfunction

  function automatic logic [RES_W-1:0] bitMask(input logic [3:0] idx);
    return 12'h001 << idx;
  endfunction

endpackage

// ===== sarc_sar_engine.sv
/*
  sarc_sar_engine: successive approximation sequencer with its own
  divided bit clock, acquisition phase and result hold register.
  Assumes start is a one-cycle pulse given only while idle and that
  compKeep is already synchronised to clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module sarc_sar_engine (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic start,
  input wire logic len8,
  input wire logic compKeep,
  output logic busy,
  output logic done,
  output logic [11:0] trialCode,
  output logic [11:0] result
);
  sarc_pkg::sarc_state_t state_q;
  logic [7:0] divCnt_q;
  logic [1:0] acqCnt_q;
  logic [3:0] idx_q;
  logic [11:0] sar_q;
  logic [11:0] hold_q;
  logic done_q;
  logic tick;

  // divided bit clock, restarted by every accepted start
  assign tick = (divCnt_q == sarc_pkg::SAR_BIT_LAST);
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      divCnt_q <= 8'h00;
    else if (clkEn)
    begin
      if (start || tick)
        divCnt_q <= 8'h00;
      else
        divCnt_q <= divCnt_q + 8'h01;
    end

  // sequencer: length is read live so a late latch still steers it
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      state_q <= sarc_pkg::ST_IDLE;
      acqCnt_q <= 2'h0;
      idx_q <= 4'h0;
      sar_q <= 12'h000;
      hold_q <= 12'h000;
      done_q <= 1'b0;
    end
    else if (clkEn)
    begin
      done_q <= 1'b0;
      case (state_q)
        sarc_pkg::ST_IDLE:
          if (start)
          begin
            sar_q <= 12'h000;
            acqCnt_q <= 2'h0;
            state_q <= sarc_pkg::ST_ACQ;
          end
        sarc_pkg::ST_ACQ:
          if (tick)
          begin
            acqCnt_q <= acqCnt_q + 2'h1;
            if (acqCnt_q == sarc_pkg::ACQ_TICKS_LAST)
            begin
              idx_q <= sarc_pkg::IDX_MSB;
              sar_q <= sarc_pkg::bitMask(sarc_pkg::IDX_MSB);
              state_q <= sarc_pkg::ST_CONV;
            end
          end
        sarc_pkg::ST_CONV:
          if (tick)
          begin
            if (sarc_pkg::isLastBit(idx_q, len8))
            begin
              if (len8)
                hold_q <= {sar_q[11:5], compKeep, sarc_pkg::PAD8};
              else
                hold_q <= {sar_q[11:1], compKeep};
              done_q <= 1'b1;
              state_q <= sarc_pkg::ST_IDLE;
            end
            else
            begin
              idx_q <= idx_q - 4'h1;
              sar_q <= (compKeep ? sar_q : sar_q & ~sarc_pkg::bitMask(idx_q))
                       | sarc_pkg::bitMask(idx_q - 4'h1);
            end
          end
        default:
          state_q <= sarc_pkg::ST_IDLE;
      endcase
    end

  assign busy = (state_q != sarc_pkg::ST_IDLE);
  assign done = done_q;
  assign trialCode = sar_q;
  assign result = hold_q;
endmodule // sarc_sar_engine
`default_nettype wire

// ===== sarc_top.sv
/*
  sarc_top: start and read control of a 12-bit successive approximation
  converter, with an AHB-Lite register slave and an interrupt output.
  Assumes the control pins and the comparator decision come from outside
  the clock domain; the analog side turns trialCode into a comparison.
*/
`timescale 1ns/1ns
`default_nettype none
module sarc_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  // converter pins
  input wire logic chipEn,
  input wire logic selN,
  input wire logic readConv,
  input wire logic wordWide,
  input wire logic length_byte_sel,
  input wire logic compKeep,
  output logic busy_status_out,
  output logic [11:0] resultData,
  output logic [11:0] resultOe,
  output logic [11:0] trialCode,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq
);
  sarc_pkg::sarc_pins_t pinsRaw;
  sarc_pkg::sarc_pins_t sync1_q;
  sarc_pkg::sarc_pins_t pins_q;
  sarc_pkg::sarc_dbus_t dbus_q;
  sarc_pkg::sarc_dbus_t dbus_d;
  logic startCond;
  logic startPrev_q;
  logic startReq;
  logic engStart;
  logic startIgn;
  logic len8_q;
  logic busy;
  logic done;
  logic [11:0] result;
  logic readCond;
  logic [11:0] tgtOe;
  logic pinStartDis_q;
  logic [1:0] intStat_q;
  logic [1:0] intEn_q;
  logic [1:0] intClr;
  logic [1:0] intSet;
  logic irq_q;
  logic addrOk;
  logic wrPend_q;
  logic rdWait_q;
  logic [7:0] apAddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdMux;

  assign pinsRaw = '{chipEn: chipEn, selN: selN, readConv: readConv,
                     wordWide: wordWide, lenByteSel: length_byte_sel,
                     compKeep: compKeep};

  // two-stage synchroniser; reset values describe an idle, deselected bus
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      sync1_q <= sarc_pkg::PINS_RST;
      pins_q <= sarc_pkg::PINS_RST;
    end
    else if (clkEn)
    begin
      sync1_q <= pinsRaw;
      pins_q <= sync1_q;
    end

  // the three start inputs are combined before the edge is taken, so
  // whichever arrives last, or all at once, starts by one path
  assign startCond = pins_q.chipEn && !pins_q.selN
                     && !pins_q.readConv;
  assign startReq = startCond && !startPrev_q && !pinStartDis_q;
  assign engStart = startReq && !busy;
  assign startIgn = startReq && busy;

  // edge memory starts low so a start level after power-up converts
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      startPrev_q <= 1'b0;
    else if (clkEn)
      startPrev_q <= startCond;

  // length select latched by every start, busy or not; a late latch
  // can shorten or stretch the conversion already running
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      len8_q <= 1'b0;
    else if (clkEn && startReq)
      len8_q <= pins_q.lenByteSel;

  // approximation engine; result is plain binary, msb first
  sarc_sar_engine u_engine (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clkEn(clkEn),
    .start(engStart),
    .len8(len8_q),
    .compKeep(pins_q.compKeep),
    .busy(busy),
    .done(done),
    .trialCode(trialCode),
    .result(result)
  );

  assign busy_status_out = busy;

  // read condition: read/convert high, idle, strobe high, selected
  assign readCond = pins_q.readConv && !busy
                    && pins_q.chipEn && !pins_q.selN;

  // lane selection for word and byte reads
  always_comb
  begin
    tgtOe = 12'h000;
    dbus_d.data = result;
    if (readCond)
    begin
      if (pins_q.wordWide)
        tgtOe = 12'hFFF;
      else if (!pins_q.lenByteSel)
      begin
        tgtOe = 12'hFF0;
        dbus_d.data = {result[11:4], 4'h0};
      end
      else
      begin
        tgtOe = 12'h0FF;
        dbus_d.data = {8'h00, result[3:0]};
      end
    end
    // a change between two live lane sets passes through all-off first,
    // so strapped bytes never fight on a shared bus
    if (dbus_q.oe != 12'h000 && tgtOe != 12'h000 && tgtOe != dbus_q.oe)
      dbus_d.oe = 12'h000;
    else
      dbus_d.oe = tgtOe;
  end

  // registered lanes: start and read exclude each other on read/convert,
  // so the enable is already off on the edge busy rises
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      dbus_q <= '0;
    else if (clkEn)
      dbus_q <= dbus_d;

  assign resultData = dbus_q.data;
  assign resultOe = dbus_q.oe;

  // bus address phase: only whole-word transfers, NONSEQ or SEQ, are taken
  assign addrOk = hsel && htrans[1] && hready
                  && (hsize == sarc_pkg::HSIZE_WORD);

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      wrPend_q <= 1'b0;
      rdWait_q <= 1'b0;
      apAddr_q <= 8'h00;
    end
    else if (clkEn)
    begin
      wrPend_q <= addrOk && hwrite;
      rdWait_q <= addrOk && !hwrite;
      if (addrOk)
        apAddr_q <= haddr[7:0];
    end

  // read mux; unmapped and write-only addresses read as zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (apAddr_q == sarc_pkg::ADDR_CTRL)
      rdMux[sarc_pkg::CTRL_PIN_DIS_BIT] = pinStartDis_q;
    else if (apAddr_q == sarc_pkg::ADDR_STATUS)
    begin
      rdMux[sarc_pkg::STAT_BUSY_BIT] = busy;
      rdMux[sarc_pkg::STAT_LEN8_BIT] = len8_q;
      rdMux[sarc_pkg::STAT_RES_LSB +: 12] = result;
    end
    else if (apAddr_q == sarc_pkg::ADDR_INT_STAT)
      rdMux[1:0] = intStat_q;
    else if (apAddr_q == sarc_pkg::ADDR_INT_EN)
      rdMux[1:0] = intEn_q;
  end

  // reads take one wait state so hrdata comes from a flip-flop
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      hrdata_q <= 32'h0000_0000;
    else if (clkEn && rdWait_q)
      hrdata_q <= rdMux;

  assign hrdata = hrdata_q;
  assign hreadyout = !rdWait_q;
  assign hresp = 1'b0;

  // control and enable registers
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      pinStartDis_q <= 1'b0;
      intEn_q <= sarc_pkg::INT_RST;
    end
    else if (clkEn && wrPend_q)
    begin
      if (apAddr_q == sarc_pkg::ADDR_CTRL)
        pinStartDis_q <= hwdata[sarc_pkg::CTRL_PIN_DIS_BIT];
      else if (apAddr_q == sarc_pkg::ADDR_INT_EN)
        intEn_q <= hwdata[1:0];
    end

  // sticky events; a set in the clearing cycle survives the clear
  assign intClr = (wrPend_q && apAddr_q == sarc_pkg::ADDR_INT_CLR)
                  ? hwdata[1:0] : 2'h0;
  always_comb
  begin
    intSet = 2'h0;
    intSet[sarc_pkg::INT_DONE_BIT] = done;
    intSet[sarc_pkg::INT_IGN_BIT] = startIgn;
  end

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      intStat_q <= sarc_pkg::INT_RST;
    else if (clkEn)
      intStat_q <= (intStat_q & ~intClr) | intSet;

  // level interrupt, registered to keep the pin glitch free
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      irq_q <= 1'b0;
    else if (clkEn)
      irq_q <= |(intStat_q & intEn_q);

  assign irq = irq_q;
endmodule // sarc_top
`default_nettype wire

// ===== sarc_checker.sv
/*
  sarc_checker: pin and bus assertions for sarc_top.
  Assumes a bind into sarc_top; pins are seen two edges late.
*/
`timescale 1ns/1ns
`default_nettype none
module sarc_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic chipEn,
  input wire logic busy_status_out,
  input wire logic [11:0] resultData,
  input wire logic [11:0] resultOe,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [7:0] runCnt_q;

  // busy run length, saturating so a stuck busy cannot wrap to a legal count
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      runCnt_q <= 8'h00;
    else if (!busy_status_out)
      runCnt_q <= 8'h00;
    else if (runCnt_q != 8'hFF)
      runCnt_q <= runCnt_q + 8'h01;

  chk_busy_len: assert property ($fell(busy_status_out) |->
    runCnt_q inside {[8'h63:8'h66], [8'h8B:8'h8E]})
    else $error("busy run length off");
  chk_float_busy: assert property (busy_status_out |->
    resultOe == 12'h000) else $error("lanes driven while busy");
  chk_lane_sets: assert property (resultOe inside
    {12'h000, 12'hFFF, 12'hFF0, 12'h0FF}) else $error("bad lane set");
  chk_low_byte: assert property (resultOe == 12'h0FF |->
    resultData[11:4] == 8'h00) else $error("low byte not padded");
  chk_high_byte: assert property (resultOe == 12'hFF0 |->
    resultData[3:0] == 4'h0) else $error("high byte lanes wrong");
  chk_break_make: assert property (resultOe != 12'h000 |=>
    resultOe == $past(resultOe) || resultOe == 12'h000)
    else $error("lane sets overlap");
  chk_strobe_off: assert property ((!chipEn)[*4] |->
    resultOe == 12'h000) else $error("lanes on with strobe low");
  chk_held_result: assert property ((resultOe == 12'hFFF &&
    $past(resultOe) == 12'hFFF) |-> $stable(resultData))
    else $error("held result moved");
  chk_read_wait: assert property ((hsel && htrans[1] && hready && !hwrite
    && hsize == 3'h2) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule // sarc_checker
`default_nettype wire

// ===== sarc_comp_model.sv
/*
  sarc_comp_model: ideal comparator in front of the converter.
  Assumes level is held steady through a conversion.
*/
`timescale 1ns/1ns
`default_nettype none
module sarc_comp_model (
  input wire logic [11:0] trialCode,
  input wire logic [11:0] level,
  output logic compKeep
);
  // keep the trial bit while the trial word is not above the held level
  assign compKeep = (trialCode <= level);
endmodule // sarc_comp_model
`default_nettype wire

// ===== sar_adc_start_read_control_bench.sv
/*
  sar_adc_start_read_control_bench: random and corner conversions, pin
  reads and register traffic for sarc_top.
  Assumes sarc_checker and sarc_comp_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module sar_adc_start_read_control_bench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic chipEn = 1'b0, selN = 1'b1, readConv = 1'b1;
  logic wordWide = 1'b1, lenSel = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [11:0] level = 12'h000, trialCode, resultData, resultOe, expR;
  logic busy, compKeep, hreadyout, hresp, irq;
  int errors = 0, checked = 0, seed = 41650, i, k;

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  sarc_top DUT (.clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1),
    .chipEn(chipEn), .selN(selN), .readConv(readConv),
    .wordWide(wordWide), .length_byte_sel(lenSel), .compKeep(compKeep),
    .busy_status_out(busy), .resultData(resultData), .resultOe(resultOe),
    .trialCode(trialCode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));
  sarc_comp_model CMP (.trialCode(trialCode), .level(level),
    .compKeep(compKeep));

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // look at hready between edges so the sampled value is never raced
  task waitRdy;
    int n;
    n = 0;
    @(negedge clk_sys);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk_sys);
    end
    if (n == 50)
      errors++;
    @(posedge clk_sys);
  endtask

  // one word transfer; read data lands in rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  // pins as {chipEn, selN, readConv}, then n idle edges
  task pins(input logic [2:0] v, input int n);
    @(posedge clk_sys);
    {chipEn, selN, readConv} <= v;
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic [11:0] expResult(input logic [11:0] v,
                                           input logic l8);
    return l8 ? {v[11:4], 4'h8} : v;
  endfunction

  task waitBusy(input logic v);
    k = 0;
    while (busy !== v && k < 300)
    begin
      k++;
      @(negedge clk_sys);
    end
    check(32'(busy), 32'(v));
  endtask

  // last: 0 strobe, 1 select, 2 read/convert, 3 all at once
  task convert(input int last, input logic l8, input int extra,
               input logic [11:0] lv);
    logic lf;
    lf = extra == 2 ? ~l8 : l8;
    @(posedge clk_sys);
    level <= lv;
    lenSel <= l8;
    pins(last == 0 ? 3'b000 : last == 1 ? 3'b110 : last == 2 ? 3'b101
      : 3'b011, 8);
    pins(3'b100, 0);
    waitBusy(1'b1);
    bus(1'b0, 32'h04, 32'h0);
    check(rd & 32'h1, 32'h1);
    if (extra != 0)
    begin
      pins(3'b101, 4);
      lenSel <= lf;
      pins(3'b100, 0);
    end
    waitBusy(1'b0);
    expR = expResult(lv, lf);
    bus(1'b0, 32'h04, 32'h0);
    check(rd & 32'h0FFF0003, {4'h0, expR, 14'h0, lf, 1'b0});
    check(32'(irq), 32'h1);
    bus(1'b0, 32'h08, 32'h0);
    check(rd & 32'h3, {30'h0, extra != 0, 1'b1});
    bus(1'b1, 32'h0C, 32'h3);
    pins(3'b101, 5);
    check(32'(irq), 32'h0);
    check(32'({resultOe, resultData}), 32'({12'hFFF, expR}));
    wordWide <= 1'b0;
    lenSel <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check(32'({resultOe, resultData}), 32'({12'hFF0, expR[11:4], 4'h0}));
    lenSel <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(32'({resultOe, resultData}), 32'({12'h0FF, 8'h0, expR[3:0]}));
    wordWide <= 1'b1;
    pins(3'b011, 5);
    check(32'(resultOe), 32'h0);
    $display("conversion of %h done", lv);
  endtask

  // main sequence: reset, registers, refused starts, conversions
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    check(32'({busy, irq, hreadyout, resultOe}), 32'h1000);
    bus(1'b0, 32'h00, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 32'h20, 32'hFFFFFFFF);
    bus(1'b0, 32'h20, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 32'h10, 32'h3);
    bus(1'b0, 32'h10, 32'h0);
    check(rd & 32'h3, 32'h3);
    // a byte-sized write must be dropped by the slave
    hsize <= 3'h0;
    bus(1'b1, 32'h10, 32'h0);
    hsize <= 3'h2;
    bus(1'b0, 32'h10, 32'h0);
    check(rd & 32'h3, 32'h3);
    $display("register tests done");
    for (i = 0; i < 3; i++)
    begin
      if (i == 2)
      begin
        bus(1'b1, 32'h00, 32'h1);
        bus(1'b0, 32'h00, 32'h0);
        check(rd, 32'h1);
      end
      pins(i == 0 ? 3'b000 : i == 1 ? 3'b110 : 3'b100, 30);
      check(32'(busy), 32'h0);
      pins(3'b011, 5);
    end
    bus(1'b1, 32'h00, 32'h0);
    $display("refused starts done");
    for (i = 0; i < 10; i++)
      convert({$random(seed)} % 4, 1'($random(seed)), 0,
        12'($random(seed)));
    convert(3, 1'b0, 1, 12'hFFF);
    convert(0, 1'b0, 2, 12'h000);
    convert(2, 1'b1, 0, 12'hA5F);
    summarize;
  end

  // watchdog well beyond the expected run of a few thousand cycles
  initial
  begin
    #400000;
    errors++;
    summarize;
  end
endmodule // sar_adc_start_read_control_bench

bind sarc_top sarc_checker CHK (.clk_sys(clk_sys), .nrst(nrst),
  .chipEn(chipEn), .busy_status_out(busy_status_out),
  .resultData(resultData), .resultOe(resultOe), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hreadyout(hreadyout));
`default_nettype wire
